//--- src/gpt_pkg.sv
`default_nettype none
package gpt_pkg;
	localparam logic [1:0]  GPT_MODE_PWM  = 2'h1;
	localparam logic [1:0]  GPT_MODE_CAP  = 2'h2;
	localparam logic [1:0]  GPT_MODE_EXT  = 2'h3;
	localparam logic [31:0] GPT_ALL_ONES  = 32'hffffffff;
	localparam logic [31:0] GPT_EVT_TOP   = 32'hfffffffe;
	localparam logic [31:0] GPT_CNT_INIT  = 32'h00000001;
	localparam logic [7:0]  GPT_OFF_STAT  = 8'h00;
	localparam logic [7:0]  GPT_OFF_CTL   = 8'h04;
	localparam logic [7:0]  GPT_OFF_CNT   = 8'h08;
	localparam logic [7:0]  GPT_OFF_PRD   = 8'h0c;
	localparam logic [7:0]  GPT_OFF_WID   = 8'h10;
	localparam int          GPT_STAT_IRQ  = 0;
	localparam int          GPT_STAT_OVF  = 1;
	localparam int          GPT_STAT_EN   = 2;
	localparam int          GPT_STAT_DIS  = 3;
	localparam int          GPT_CTL_MODE  = 0;
	localparam int          GPT_CTL_PULSE = 2;
	localparam int          GPT_CTL_PRDC  = 3;
	localparam int          GPT_CTL_INTERRUPT_ENABLE_BIT = 4;
	localparam int          GPT_EN_LAT    = 3;
	localparam int          GPT_DIS_LAT   = 2;
	localparam logic [1:0]  GPT_RESP_OK   = 2'h0;
	localparam logic [1:0]  GPT_RESP_ERR  = 2'h2;
	typedef enum logic [1:0] {GPT_IDLE, GPT_WAIT, GPT_CAP1, GPT_RUN} gpt_state_t;
endpackage
`default_nettype wire

//--- src/gpt_sync.sv
`default_nettype none
module gpt_sync #(
	parameter int STAGES = 2
) (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_async,
	output logic      o_sync
);
	logic [STAGES-1:0] sync_q;
	// only the last stage leaves the module
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sync_q <= '0;
		end else begin
			sync_q <= {sync_q[STAGES-2:0], i_async};
		end
	end
	assign o_sync = sync_q[STAGES-1];
endmodule
`default_nettype wire

//--- src/gpt_timer.sv
// The AXI4-Lite register port and the address map are this design's own decisions.
`default_nettype none
module gpt_timer
	import gpt_pkg::*;
(
	input  wire logic        I_SYS_CLK,
	input  wire logic        I_SYS_RST,
	input  wire logic [7:0]  I_AWADDR,
	input  wire logic        I_AWVALID,
	output logic             O_AWREADY,
	input  wire logic [31:0] I_WDATA,
	input  wire logic [3:0]  I_WSTRB,
	input  wire logic        I_WVALID,
	output logic             O_WREADY,
	output logic [1:0]       O_BRESP,
	output logic             O_BVALID,
	input  wire logic        I_BREADY,
	input  wire logic [7:0]  I_ARADDR,
	input  wire logic        I_ARVALID,
	output logic             O_ARREADY,
	output logic [31:0]      O_RDATA,
	output logic [1:0]       O_RRESP,
	output logic             O_RVALID,
	input  wire logic        I_RREADY,
	input  wire logic        I_TIMER_IN,
	input  wire logic        I_EMU_HALT,
	output logic             O_TIMER_OUT,
	output logic             O_TIMER_OE,
	output logic             O_IRQ
);
	// ---------------------------------------------------------------
	// axi4-lite write path
	// ---------------------------------------------------------------
	logic [7:0]  awaddr_q;
	logic        aw_have_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        w_have_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        wr_fire;
	logic        wr_hit;

	assign O_AWREADY = !aw_have_q && !bvalid_q;
	assign O_WREADY  = !w_have_q && !bvalid_q;
	assign wr_fire   = aw_have_q && w_have_q && !bvalid_q;
	assign wr_hit    = (awaddr_q[7:2] <= GPT_OFF_WID[7:2]) && (awaddr_q[1:0] == 2'h0);
	assign O_BVALID  = bvalid_q;
	assign O_BRESP   = bresp_q;

	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			awaddr_q  <= 8'h00;
			aw_have_q <= 1'b0;
			wdata_q   <= 32'h00000000;
			wstrb_q   <= 4'h0;
			w_have_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= GPT_RESP_OK;
		end else begin
			if (I_AWVALID && O_AWREADY) begin
				awaddr_q  <= I_AWADDR;
				aw_have_q <= 1'b1;
			end
			if (I_WVALID && O_WREADY) begin
				wdata_q  <= I_WDATA;
				wstrb_q  <= I_WSTRB;
				w_have_q <= 1'b1;
			end
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_hit ? GPT_RESP_OK : GPT_RESP_ERR;
			end else if (bvalid_q && I_BREADY) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	logic wr_stat;
	logic wr_ctl;
	logic wr_prd;
	logic wr_wid;
	assign wr_stat = wr_fire && wr_hit && awaddr_q == GPT_OFF_STAT && wstrb_q[0];
	assign wr_ctl  = wr_fire && wr_hit && awaddr_q == GPT_OFF_CTL;
	assign wr_prd  = wr_fire && wr_hit && awaddr_q == GPT_OFF_PRD;
	assign wr_wid  = wr_fire && wr_hit && awaddr_q == GPT_OFF_WID;

	// ---------------------------------------------------------------
	// control and value registers
	// ---------------------------------------------------------------
	logic [4:0]  ctl_q;
	logic [31:0] prd_q;
	logic [31:0] wid_q;
	logic [1:0]  mode;
	logic        pulse;
	logic        period_count_select;
	logic        interrupt_enable_bit;
	assign mode   = ctl_q[GPT_CTL_MODE +: 2];
	assign pulse  = ctl_q[GPT_CTL_PULSE];
	assign period_count_select = ctl_q[GPT_CTL_PRDC];
	assign interrupt_enable_bit  = ctl_q[GPT_CTL_INTERRUPT_ENABLE_BIT];

	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			ctl_q <= 5'h00;
		end else if (wr_ctl && wstrb_q[0]) begin
			ctl_q <= wdata_q[4:0];
		end
	end

	// capture events write period and width; software writes only outside capture mode
	logic        cap_wid;
	logic        cap_prd;
	logic        clr_prd;
	logic [31:0] cnt_q;
	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			prd_q <= 32'h00000000;
			wid_q <= 32'h00000000;
		end else begin
			if (clr_prd) begin
				prd_q <= 32'h00000000;
			end else if (cap_prd) begin
				prd_q <= {1'b0, cnt_q[31:1]};
			end else if (wr_prd && mode != GPT_MODE_CAP) begin
				prd_q <= merge(prd_q, wdata_q, wstrb_q);
			end
			if (cap_wid) begin
				wid_q <= {1'b0, cnt_q[31:1]};
			end else if (wr_wid && mode != GPT_MODE_CAP) begin
				wid_q <= merge(wid_q, wdata_q, wstrb_q);
			end
		end
	end

	// ---------------------------------------------------------------
	// enable and disable latency
	// ---------------------------------------------------------------
	logic                   en_q;
	logic [GPT_EN_LAT-1:0]  en_pipe_q;
	logic [GPT_DIS_LAT-1:0] dis_pipe_q;
	logic                   start_pulse;
	logic                   stop_pulse;
	logic                   auto_stop;
	assign start_pulse = en_pipe_q[GPT_EN_LAT-1];
	assign stop_pulse  = dis_pipe_q[GPT_DIS_LAT-1];

	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			en_pipe_q  <= '0;
			dis_pipe_q <= '0;
		end else begin
			en_pipe_q  <= {en_pipe_q[GPT_EN_LAT-2:0],
				wr_stat && wdata_q[GPT_STAT_EN] && !en_q};
			dis_pipe_q <= {dis_pipe_q[GPT_DIS_LAT-2:0],
				wr_stat && wdata_q[GPT_STAT_DIS]};
		end
	end

	// enable bit reads back set from the write onward until the stop takes effect
	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			en_q <= 1'b0;
		end else if (stop_pulse || auto_stop) begin
			en_q <= 1'b0;
		end else if (wr_stat && wdata_q[GPT_STAT_EN]) begin
			en_q <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// input pin synchroniser and edge detect
	// ---------------------------------------------------------------
	logic pin_s;
	logic pin_d_q;
	logic rise;
	logic fall;
	logic lead;
	logic trail;
	gpt_sync #(.STAGES(2)) u_sync (
		.i_clk   (I_SYS_CLK),
		.i_rst   (I_SYS_RST),
		.i_async (I_TIMER_IN),
		.o_sync  (pin_s)
	);
	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			pin_d_q <= 1'b0;
		end else begin
			pin_d_q <= pin_s;
		end
	end
	assign rise  = pin_s && !pin_d_q;
	assign fall  = !pin_s && pin_d_q;
	assign lead  = pulse ? rise : fall;
	assign trail = pulse ? fall : rise;

	// ---------------------------------------------------------------
	// counter sequencing; emulation halt is deliberately not looked at
	// ---------------------------------------------------------------
	gpt_state_t st_q;
	logic       irq_set;
	logic       ovf_set;
	logic       pwm_bad;
	logic       cnt_top;
	assign pwm_bad = (wid_q == 32'h0) || (prd_q <= wid_q);
	assign cnt_top = (cnt_q == GPT_ALL_ONES);

	// event mode next count: the first rise and the rise after the top both load from period
	logic [31:0] evt_next;
	assign evt_next = (st_q == GPT_WAIT || cnt_q == GPT_EVT_TOP) ? GPT_ALL_ONES - prd_q
		: cnt_q + 32'h1;

	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			st_q  <= GPT_IDLE;
			cnt_q <= 32'h00000000;
		end else if (stop_pulse || auto_stop) begin
			st_q <= GPT_IDLE;
		end else if (start_pulse) begin
			case (mode)
				GPT_MODE_CAP: begin
					cnt_q <= GPT_CNT_INIT;
					st_q  <= GPT_WAIT;
				end
				GPT_MODE_EXT: st_q <= GPT_WAIT;
				GPT_MODE_PWM: begin
					if (!pwm_bad) begin
						cnt_q <= GPT_ALL_ONES - wid_q;
						st_q  <= GPT_RUN;
					end
				end
				default: st_q <= GPT_IDLE;
			endcase
		end else begin
			case (st_q)
				GPT_IDLE: st_q <= GPT_IDLE;
				GPT_WAIT: begin
					if (mode == GPT_MODE_CAP && lead) begin
						st_q <= GPT_CAP1;
					end else if (mode == GPT_MODE_EXT && rise) begin
						cnt_q <= evt_next;
						st_q  <= GPT_RUN;
					end
				end
				GPT_CAP1, GPT_RUN: begin
					if (mode == GPT_MODE_EXT) begin
						if (rise) begin
							cnt_q <= evt_next;
						end
					end else if (mode == GPT_MODE_CAP && lead && st_q == GPT_RUN) begin
						cnt_q <= GPT_CNT_INIT;
					end else if (mode == GPT_MODE_PWM && cnt_top) begin
						cnt_q <= GPT_ALL_ONES - (prd_q - wid_q);
					end else if (!cnt_top) begin
						cnt_q <= cnt_q + 32'h1;
					end
					if (mode == GPT_MODE_CAP && trail && st_q == GPT_CAP1) begin
						st_q <= GPT_RUN;
					end
				end
				default: st_q <= GPT_IDLE;
			endcase
		end
	end

	logic first_q;
	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			first_q <= 1'b0;
		end else if (start_pulse) begin
			first_q <= 1'b1;
		end else if (cap_wid) begin
			first_q <= 1'b0;
		end
	end

	assign cap_wid   = mode == GPT_MODE_CAP && st_q == GPT_CAP1 && trail && !start_pulse;
	assign cap_prd   = mode == GPT_MODE_CAP && st_q == GPT_RUN && lead && !start_pulse;
	assign clr_prd   = cap_wid && first_q;
	assign auto_stop = (st_q == GPT_CAP1 || st_q == GPT_RUN) && mode == GPT_MODE_CAP
		&& cnt_top;
	// pwm pin drive level only; detailed pwm sequencing lives elsewhere
	assign O_TIMER_OE  = (mode == GPT_MODE_PWM);
	assign O_TIMER_OUT = (st_q == GPT_RUN) ? pulse : !pulse;

	always_comb begin
		irq_set = 1'b0;
		ovf_set = auto_stop;
		if (mode == GPT_MODE_CAP) begin
			irq_set = period_count_select ? cap_prd : cap_wid;
		end else if (mode == GPT_MODE_EXT) begin
			// latch as the count arrives at the top, not on the reloading rise
			irq_set = (st_q == GPT_WAIT || st_q == GPT_RUN) && rise && evt_next == GPT_EVT_TOP
				&& !start_pulse && !stop_pulse;
		end else if (mode == GPT_MODE_PWM && start_pulse && pwm_bad) begin
			irq_set = 1'b1;
			ovf_set = 1'b1;
		end
		irq_set = (irq_set || auto_stop) && interrupt_enable_bit;
	end

	// ---------------------------------------------------------------
	// sticky status flags, set wins over write-one-to-clear
	// ---------------------------------------------------------------
	logic irq_q;
	logic ovf_q;
	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			irq_q <= 1'b0;
			ovf_q <= 1'b0;
		end else begin
			if (irq_set) begin
				irq_q <= 1'b1;
			end else if (wr_stat && wdata_q[GPT_STAT_IRQ]) begin
				irq_q <= 1'b0;
			end
			if (ovf_set) begin
				ovf_q <= 1'b1;
			end else if (wr_stat && wdata_q[GPT_STAT_OVF]) begin
				ovf_q <= 1'b0;
			end
		end
	end
	assign O_IRQ = irq_q;

	// ---------------------------------------------------------------
	// axi4-lite read path
	// ---------------------------------------------------------------
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	assign O_ARREADY = !rvalid_q;
	assign O_RVALID  = rvalid_q;
	assign O_RDATA   = rdata_q;
	assign O_RRESP   = rresp_q;
	always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h00000000;
			rresp_q  <= GPT_RESP_OK;
		end else if (I_ARVALID && O_ARREADY) begin
			rvalid_q <= 1'b1;
			rresp_q  <= GPT_RESP_OK;
			case (I_ARADDR)
				GPT_OFF_STAT: rdata_q <= {28'h0, 1'b0, en_q, ovf_q, irq_q};
				GPT_OFF_CTL:  rdata_q <= {27'h0, ctl_q};
				GPT_OFF_CNT:  rdata_q <= cnt_q;
				GPT_OFF_PRD:  rdata_q <= prd_q;
				GPT_OFF_WID:  rdata_q <= wid_q;
				default: begin
					rdata_q <= 32'h00000000;
					rresp_q <= GPT_RESP_ERR;
				end
			endcase
		end else if (rvalid_q && I_RREADY) begin
			rvalid_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	property p_en_lat;
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(wr_stat && wdata_q[GPT_STAT_EN] && !en_q && !wdata_q[GPT_STAT_DIS])
			|-> ##3 start_pulse;
	endproperty
	a_en_lat: assert property (p_en_lat) else $error("start not three cycles after enable");

	property p_dis_lat;
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(wr_stat && wdata_q[GPT_STAT_DIS]) |-> ##3 (st_q == GPT_IDLE && !en_q) [*2];
	endproperty
	a_dis_lat: assert property (p_dis_lat) else $error("timer not stopped after disable");

	property p_ovf_stop;
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		auto_stop |=> (ovf_q && !en_q && st_q == GPT_IDLE);
	endproperty
	a_ovf_stop: assert property (p_ovf_stop) else $error("overflow did not stop timer");

	property p_interrupt_enable_bit;
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(!interrupt_enable_bit && !irq_q) |=> !irq_q;
	endproperty
	a_interrupt_enable_bit: assert property (p_interrupt_enable_bit) else $error("irq latched while disabled");

	property p_sticky;
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(irq_q && !(wr_stat && wdata_q[GPT_STAT_IRQ])) |=> irq_q;
	endproperty
	a_sticky: assert property (p_sticky) else $error("irq latch dropped without clear");

	property p_wid_cap;
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		cap_wid |=> (wid_q == {1'b0, $past(cnt_q[31:1])});
	endproperty
	a_wid_cap: assert property (p_wid_cap) else $error("width not half of count");

	property p_prd_restart;
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		cap_prd |=> (cnt_q == GPT_CNT_INIT && prd_q == {1'b0, $past(cnt_q[31:1])});
	endproperty
	a_prd_restart: assert property (p_prd_restart) else $error("period capture wrong");

	property p_ext_ovf;
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(mode == GPT_MODE_EXT && !ovf_q && !start_pulse) |=> !ovf_q;
	endproperty
	a_ext_ovf: assert property (p_ext_ovf) else $error("overflow set in event mode");

	property p_ext_reload;
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		(mode == GPT_MODE_EXT && st_q == GPT_RUN && cnt_q == GPT_EVT_TOP && rise
			&& !start_pulse && !stop_pulse)
			|=> (cnt_q == GPT_ALL_ONES - $past(prd_q));
	endproperty
	a_ext_reload: assert property (p_ext_reload) else $error("event reload wrong");
endmodule
`default_nettype wire

//--- tb/gpt_src.sv
`default_nettype none
module gpt_src (
	input  wire logic i_clk,
	output logic      o_pin
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		o_pin = 1'b0;
	end

	// ---------------------------------------------------------------
	// waveform and event source
	// ---------------------------------------------------------------
	// level changes land mid-cycle: the pin is asynchronous to the core clock
	task automatic hold(input logic lvl, input int n);
		@(posedge i_clk);
		#3 o_pin = lvl;
		repeat (n) @(posedge i_clk);
	endtask

	// each event is one rise; the falls between them must not count
	task automatic rises(input int n);
		repeat (n) begin
			hold(1'b1, 3);
			hold(1'b0, 3);
		end
	endtask
endmodule
`default_nettype wire

//--- tb/general_purpose_timer_test.sv
`default_nettype none
module general_purpose_timer_test;
	import gpt_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, emu;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rd, c1;
	logic [3:0]  wstrb;
	logic [1:0]  rsp;
	wire logic   awready, wready, bvalid, arready, rvalid, tout, toe, irq, src_pin, pin;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	int          miscompares, tests_run, seed, cycles, h, p, t1, t2;

	// the timer drives the pin only while its output enable is high
	assign pin = toe ? tout : src_pin;

	gpt_timer i_gpt_timer (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_AWADDR(awaddr),
		.I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb),
		.I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
		.I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
		.O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
		.I_TIMER_IN(pin), .I_EMU_HALT(emu), .O_TIMER_OUT(tout), .O_TIMER_OE(toe),
		.O_IRQ(irq));
	gpt_src i_gpt_src (.i_clk(clk), .o_pin(src_pin));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ---------------------------------------------------------------
	// checking and closing
	// ---------------------------------------------------------------
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask

	// capture runs through a synchroniser, so a couple of clocks of slack are allowed
	function automatic logic [31:0] near(input logic [31:0] v, input int e);
		return (int'(v) >= e - 2 && int'(v) <= e + 2) ? 32'h1 : 32'h0;
	endfunction

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			miscompares++;
			wrap_up();
		end
	end

	// ---------------------------------------------------------------
	// register bus master
	// ---------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_hit, w_hit, b_hit;
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= 4'hf;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		b_hit = 1'b0;
		while (!b_hit) begin
			@(negedge clk);
			aw_hit = awvalid & awready;
			w_hit  = wvalid & wready;
			b_hit  = bvalid;
			rsp    = bresp;
			@(posedge clk);
			if (aw_hit) awvalid <= 1'b0;
			if (w_hit) wvalid <= 1'b0;
			if (b_hit) bready <= 1'b0;
		end
	endtask

	task automatic rdr(input logic [7:0] a);
		logic ar_hit, r_hit;
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		r_hit = 1'b0;
		while (!r_hit) begin
			@(negedge clk);
			ar_hit = arvalid & arready;
			r_hit  = rvalid;
			rd     = rdata;
			rsp    = rresp;
			@(posedge clk);
			if (ar_hit) arvalid <= 1'b0;
			if (r_hit) rready <= 1'b0;
		end
	endtask

	task automatic enable_after(input logic [31:0] ctl);
		wr(GPT_OFF_CTL, ctl);
		repeat (2) @(posedge clk);
		wr(GPT_OFF_STAT, 32'h00000004);
		repeat (8) @(posedge clk);
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, emu} = 6'h00;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		miscompares = 0;
		tests_run = 0;
		cycles = 0;
		seed = 31;
		rst = 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;

		for (int a = 0; a <= 16; a += 4) begin
			rdr(8'(a));
			chk("reset value", rd, 32'h0);
			chk("read resp", {30'h0, rsp}, {30'h0, GPT_RESP_OK});
		end
		rdr(8'h14);
		chk("unmapped read resp", {30'h0, rsp}, {30'h0, GPT_RESP_ERR});
		wr(8'h20, 32'h1);
		chk("unmapped write resp", {30'h0, rsp}, {30'h0, GPT_RESP_ERR});
		chk("idle oe", {31'h0, toe}, 32'h0);
		$display("test reset done");

		h = 10 + ($random(seed) & 31);
		enable_after(32'h00000016);
		emu <= 1'b1;
		i_gpt_src.hold(1'b1, h);
		t1 = cycles - h;
		i_gpt_src.hold(1'b0, 6);
		rdr(GPT_OFF_STAT);
		chk("width irq", rd, 32'h5);
		chk("irq pin", {31'h0, irq}, 32'h1);
		rdr(GPT_OFF_PRD);
		chk("first period", rd, 32'h0);
		rdr(GPT_OFF_WID);
		chk("high width", near(rd, h / 2), 32'h1);
		i_gpt_src.hold(1'b1, 6);
		t2 = cycles - 6;
		rdr(GPT_OFF_PRD);
		chk("period", near(rd, (t2 - t1) / 2), 32'h1);
		wr(GPT_OFF_STAT, 32'h1);
		rdr(GPT_OFF_STAT);
		chk("irq cleared", rd, 32'h4);
		wr(GPT_OFF_STAT, 32'h8);
		repeat (4) @(posedge clk);
		rdr(GPT_OFF_STAT);
		chk("disabled", rd, 32'h0);
		rdr(GPT_OFF_CNT);
		c1 = rd;
		repeat (10) @(posedge clk);
		rdr(GPT_OFF_CNT);
		chk("count held", rd, c1);
		emu <= 1'b0;
		$display("test capture high done");

		h = 10 + ($random(seed) & 31);
		enable_after(32'h0000001a);
		i_gpt_src.hold(1'b0, h);
		t1 = cycles - h;
		i_gpt_src.hold(1'b1, 6);
		rdr(GPT_OFF_STAT);
		chk("no irq at width", rd, 32'h4);
		rdr(GPT_OFF_WID);
		chk("low width", near(rd, h / 2), 32'h1);
		i_gpt_src.hold(1'b0, 6);
		t2 = cycles - 6;
		rdr(GPT_OFF_STAT);
		chk("period irq", rd, 32'h5);
		rdr(GPT_OFF_PRD);
		chk("low period", near(rd, (t2 - t1) / 2), 32'h1);
		wr(GPT_OFF_STAT, 32'h9);
		repeat (4) @(posedge clk);
		rdr(GPT_OFF_STAT);
		chk("clear with disable", rd, 32'h0);
		$display("test capture low done");

		for (int ie = 1; ie >= 0; ie--) begin
			p = 3 + ($random(seed) & 3);
			wr(GPT_OFF_CTL, 32'h0b | (32'(ie) << 4));
			chk("event oe", {31'h0, toe}, 32'h0);
			wr(GPT_OFF_PRD, 32'(p));
			enable_after(32'h0b | (32'(ie) << 4));
			// the first rise loads, so p - 1 rises stop one short of the top
			i_gpt_src.rises(p - 1);
			rdr(GPT_OFF_STAT);
			chk("before expiry", rd, 32'h4);
			i_gpt_src.rises(1);
			rdr(GPT_OFF_STAT);
			chk("expiry", rd, ie ? 32'h5 : 32'h4);
			wr(GPT_OFF_STAT, 32'h1);
			// reload rise plus p - 1 increments reaches the top again
			i_gpt_src.rises(p);
			rdr(GPT_OFF_STAT);
			chk("second expiry", rd, ie ? 32'h5 : 32'h4);
			wr(GPT_OFF_STAT, 32'h9);
		end
		$display("test event done");

		wr(GPT_OFF_CTL, 32'h11);
		chk("pwm oe", {31'h0, toe}, 32'h1);
		chk("pwm idle level", {31'h0, tout}, 32'h1);
		for (int w = 0; w <= 5; w += 5) begin
			wr(GPT_OFF_PRD, 32'h5);
			wr(GPT_OFF_WID, 32'(w));
			wr(GPT_OFF_STAT, 32'h4);
			repeat (8) @(posedge clk);
			rdr(GPT_OFF_STAT);
			chk("pwm bounds", rd & 32'h3, 32'h3);
			wr(GPT_OFF_STAT, 32'hb);
		end
		$display("test waveform bounds done");
		wrap_up();
	end
endmodule
`default_nettype wire
